// >>> ogt_pkg.sv
package ogt_pkg;

    // ==========================================================
    // bus geometry
    localparam int          PADDR_W   = 12;
    localparam int          PDATA_W   = 32;
    localparam int          REG_W     = 16;
    localparam int          OFS_W     = 12;
    localparam int          GAIN_W    = 5;
    localparam int          NUM_TRIM  = 10;
    localparam int          SLOT_W    = 4;
    localparam logic [1:0]  BYTE_SHIFT = 2'h2;

    // ==========================================================
    // register indices, byte address is index times four
    localparam logic [PADDR_W-1:0] IDX_CORE3_OFFSET_INPUT_C  = 12'h338;
    localparam logic [PADDR_W-1:0] IDX_CORE3_OFFSET_INPUT_D  = 12'h33a;
    localparam logic [PADDR_W-1:0] IDX_CORE4_OFFSET   = 12'h33c;
    localparam logic [PADDR_W-1:0] IDX_CORE5_OFFSET   = 12'h33e;
    localparam logic [PADDR_W-1:0] IDX_CORE0_FINE_GAIN  = 12'h360;
    localparam logic [PADDR_W-1:0] IDX_CORE1_FINE_GAIN  = 12'h361;
    localparam logic [PADDR_W-1:0] IDX_CORE2_FINE_GAIN_INPUT_A = 12'h362;
    localparam logic [PADDR_W-1:0] IDX_CORE2_FINE_GAIN_INPUT_B = 12'h363;
    localparam logic [PADDR_W-1:0] IDX_CORE3_FINE_GAIN_INPUT_C = 12'h364;
    localparam logic [PADDR_W-1:0] IDX_CORE3_FINE_GAIN_INPUT_D = 12'h365;
    localparam logic [PADDR_W-1:0] IDX_CTRL   = 12'h370;
    localparam logic [PADDR_W-1:0] IDX_STATUS = 12'h371;

    // ==========================================================
    // storage slots, also the fuse word order
    localparam logic [SLOT_W-1:0] SLOT_CORE3_OFFSET_INPUT_C  = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_CORE3_OFFSET_INPUT_D  = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_CORE4_OFFSET   = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_CORE5_OFFSET   = 4'h3;
    localparam logic [SLOT_W-1:0] SLOT_CORE0_FINE_GAIN  = 4'h4;
    localparam logic [SLOT_W-1:0] SLOT_CORE1_FINE_GAIN  = 4'h5;
    localparam logic [SLOT_W-1:0] SLOT_CORE2_FINE_GAIN_INPUT_A = 4'h6;
    localparam logic [SLOT_W-1:0] SLOT_CORE2_FINE_GAIN_INPUT_B = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_CORE3_FINE_GAIN_INPUT_C = 4'h8;
    localparam logic [SLOT_W-1:0] SLOT_CORE3_FINE_GAIN_INPUT_D = 4'h9;
    localparam logic [SLOT_W-1:0] SLOT_LAST   = 4'h9;

    // ==========================================================
    // field layouts and reset values
    localparam logic [REG_W-1:0] OFS_MASK   = 16'hffff;
    localparam logic [REG_W-1:0] GAIN_MASK  = 16'h00ff;
    localparam logic [REG_W-1:0] TRIM_RST   = 16'h0000;
    localparam int               CTRL_RELOAD  = 0;
    localparam int               ST_FUSE_DONE = 0;
    localparam int               ST_LOADING   = 1;
    localparam int               ST_CAL_BUSY  = 2;
    localparam int               ST_SEL_B     = 3;
    localparam int               ST_SEL_D     = 4;

    function automatic logic [REG_W-1:0] slotMask(input logic [SLOT_W-1:0] slot);
        slotMask = (slot >= SLOT_CORE0_FINE_GAIN) ? GAIN_MASK : OFS_MASK;
    endfunction : slotMask

    function automatic logic isOffsetSlot(input logic [SLOT_W-1:0] slot);
        isOffsetSlot = (slot < SLOT_CORE0_FINE_GAIN);
    endfunction : isOffsetSlot

endpackage : ogt_pkg

// >>> ogt_load_if.sv
interface ogt_load_if;
    logic                             start;
    logic                             wrEn;
    logic [ogt_pkg::SLOT_W-1:0]       slot;
    logic [ogt_pkg::REG_W-1:0]        data;
    logic                             busy;

    modport regs   (output start, input wrEn, input slot, input data, input busy);
    modport loader (input start, output wrEn, output slot, output data, output busy);
endinterface : ogt_load_if

// >>> ogt_fuse_loader.sv
module ogt_fuse_loader (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic [ogt_pkg::REG_W-1:0]  fuseData,
    output logic      [ogt_pkg::SLOT_W-1:0] fuseAddr,
    ogt_load_if.loader                      ld
);

    // ==========================================================
    // state
    typedef enum logic [1:0] {
        LD_IDLE = 2'b01,
        LD_RUN  = 2'b10
    } ogt_ld_state_t;

    typedef struct packed {
        ogt_ld_state_t               state;
        logic [ogt_pkg::SLOT_W-1:0]  addr;
        logic                        wrEn;
        logic [ogt_pkg::SLOT_W-1:0]  slot;
        logic [ogt_pkg::REG_W-1:0]   data;
        logic                        busy;
    } ogt_ld_t;

    ogt_ld_t s_r;
    ogt_ld_t s_nxt;

    // ==========================================================
    // sequencer: fuse array reads combinationally, one word per cycle
    always_comb begin
        s_nxt      = s_r;
        s_nxt.wrEn = 1'b0;
        unique case (s_r.state)
            LD_IDLE: begin
                s_nxt.busy = 1'b0;
                if (ld.start) begin
                    s_nxt.state = LD_RUN;
                    s_nxt.addr  = ogt_pkg::SLOT_CORE3_OFFSET_INPUT_C;
                    s_nxt.busy  = 1'b1;
                end
            end
            LD_RUN: begin
                s_nxt.wrEn = 1'b1;
                s_nxt.slot = s_r.addr;
                s_nxt.data = fuseData;
                if (s_r.addr == ogt_pkg::SLOT_LAST) begin
                    s_nxt.state = LD_IDLE;
                end else begin
                    s_nxt.addr = s_r.addr + 4'h1;
                end
            end
        endcase
    end

    // reset starts a load at once, so fuse values replace the zero reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r.state <= LD_RUN;
            s_r.addr  <= ogt_pkg::SLOT_CORE3_OFFSET_INPUT_C;
            s_r.wrEn  <= 1'b0;
            s_r.slot  <= ogt_pkg::SLOT_CORE3_OFFSET_INPUT_C;
            s_r.data  <= ogt_pkg::TRIM_RST;
            s_r.busy  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fuseAddr = s_r.addr;
    assign ld.wrEn  = s_r.wrEn;
    assign ld.slot  = s_r.slot;
    assign ld.data  = s_r.data;
    assign ld.busy  = s_r.busy;

endmodule : ogt_fuse_loader

// >>> ogt_trim_regs.sv
// Decided for this implementation: the APB register port.
module ogt_trim_regs (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic [ogt_pkg::PADDR_W-1:0]   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ogt_pkg::PDATA_W-1:0]   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [ogt_pkg::PDATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          core2SelB,
    input  wire logic                          core3SelD,
    input  wire logic                          calBusy,
    input  wire logic [ogt_pkg::REG_W-1:0]     fuseData,
    output logic      [ogt_pkg::SLOT_W-1:0]    fuseAddr,
    output logic      [ogt_pkg::GAIN_W-1:0]    core0Gain,
    output logic      [ogt_pkg::GAIN_W-1:0]    core1Gain,
    output logic      [ogt_pkg::GAIN_W-1:0]    core2Gain,
    output logic      [ogt_pkg::GAIN_W-1:0]    core3Gain,
    output logic      [ogt_pkg::OFS_W-1:0]     core3Offset,
    output logic      [ogt_pkg::OFS_W-1:0]     core4Offset,
    output logic      [ogt_pkg::OFS_W-1:0]     core5Offset,
    output logic                               fuseLoading
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [ogt_pkg::NUM_TRIM-1:0][ogt_pkg::REG_W-1:0] trim;
        logic [ogt_pkg::PDATA_W-1:0]                      prdata;
        logic                                             pready;
        logic                                             pslverr;
        logic                                             start;
        logic                                             fuseDone;
        logic [ogt_pkg::GAIN_W-1:0]                       core0_fine_gain;
        logic [ogt_pkg::GAIN_W-1:0]                       core1_fine_gain;
        logic [ogt_pkg::GAIN_W-1:0]                       gain2;
        logic [ogt_pkg::GAIN_W-1:0]                       gain3;
        logic [ogt_pkg::OFS_W-1:0]                        ofs3;
        logic [ogt_pkg::OFS_W-1:0]                        core4_offset;
        logic [ogt_pkg::OFS_W-1:0]                        core5_offset;
    } ogt_regs_t;

    ogt_regs_t s_r;
    ogt_regs_t s_nxt;

    ogt_load_if ld ();

    // ==========================================================
    // fuse loader
    ogt_fuse_loader u_loader (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .fuseData (fuseData),
        .fuseAddr (fuseAddr),
        .ld       (ld.loader)
    );

    assign ld.start = s_r.start;

    // ==========================================================
    // address decode
    logic [ogt_pkg::PADDR_W-1:0] regIdx;
    logic                        aligned;
    logic                        hitTrim;
    logic                        hitCtrl;
    logic                        hitStatus;
    logic [ogt_pkg::SLOT_W-1:0]  slot;
    logic                        calBlock;
    logic [ogt_pkg::REG_W-1:0]   laneMask;
    logic [ogt_pkg::REG_W-1:0]   statusWord;

    always_comb begin
        regIdx    = paddr >> ogt_pkg::BYTE_SHIFT;
        aligned   = (paddr[1:0] == 2'h0);
        hitTrim   = 1'b1;
        hitCtrl   = aligned && (regIdx == ogt_pkg::IDX_CTRL);
        hitStatus = aligned && (regIdx == ogt_pkg::IDX_STATUS);
        slot      = ogt_pkg::SLOT_CORE3_OFFSET_INPUT_C;
        unique case (regIdx)
            ogt_pkg::IDX_CORE3_OFFSET_INPUT_C:  slot = ogt_pkg::SLOT_CORE3_OFFSET_INPUT_C;
            ogt_pkg::IDX_CORE3_OFFSET_INPUT_D:  slot = ogt_pkg::SLOT_CORE3_OFFSET_INPUT_D;
            ogt_pkg::IDX_CORE4_OFFSET:   slot = ogt_pkg::SLOT_CORE4_OFFSET;
            ogt_pkg::IDX_CORE5_OFFSET:   slot = ogt_pkg::SLOT_CORE5_OFFSET;
            ogt_pkg::IDX_CORE0_FINE_GAIN:  slot = ogt_pkg::SLOT_CORE0_FINE_GAIN;
            ogt_pkg::IDX_CORE1_FINE_GAIN:  slot = ogt_pkg::SLOT_CORE1_FINE_GAIN;
            ogt_pkg::IDX_CORE2_FINE_GAIN_INPUT_A: slot = ogt_pkg::SLOT_CORE2_FINE_GAIN_INPUT_A;
            ogt_pkg::IDX_CORE2_FINE_GAIN_INPUT_B: slot = ogt_pkg::SLOT_CORE2_FINE_GAIN_INPUT_B;
            ogt_pkg::IDX_CORE3_FINE_GAIN_INPUT_C: slot = ogt_pkg::SLOT_CORE3_FINE_GAIN_INPUT_C;
            ogt_pkg::IDX_CORE3_FINE_GAIN_INPUT_D: slot = ogt_pkg::SLOT_CORE3_FINE_GAIN_INPUT_D;
            default:             hitTrim = 1'b0;
        endcase
        hitTrim = hitTrim && aligned;
        // offset words are not safe to touch mid calibration; refuse loudly
        calBlock = calBusy && hitTrim && ogt_pkg::isOffsetSlot(slot);
        laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        statusWord = '0;
        statusWord[ogt_pkg::ST_FUSE_DONE] = s_r.fuseDone;
        statusWord[ogt_pkg::ST_LOADING]   = ld.busy;
        statusWord[ogt_pkg::ST_CAL_BUSY]  = calBusy;
        statusWord[ogt_pkg::ST_SEL_B]     = core2SelB;
        statusWord[ogt_pkg::ST_SEL_D]     = core3SelD;
    end

    // ==========================================================
    // next state
    logic accessDone;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.start   = 1'b0;
        accessDone    = psel && penable && s_r.pready;

        // setup cycle: answer is ready for the first access cycle
        if (psel && !penable) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !(hitTrim || hitCtrl || hitStatus) || calBlock;
            s_nxt.prdata  = '0;
            if (!pwrite && hitTrim && !calBlock) begin
                // reserved offset bits and gain bits 7:5 are plain storage and read back as written; gain bits 15:8 read zero
                s_nxt.prdata[ogt_pkg::REG_W-1:0] = s_r.trim[slot];
            end else if (!pwrite && hitStatus) begin
                s_nxt.prdata[ogt_pkg::REG_W-1:0] = statusWord;
            end
        end

        // write lands on the completing edge only
        if (accessDone && pwrite && !s_r.pslverr) begin
            if (hitTrim) begin
                // reserved bits stored as given except gain bits 15:8, which clear; software keeps them zero
                s_nxt.trim[slot] = (s_r.trim[slot] & ~laneMask)
                                 | (pwdata[ogt_pkg::REG_W-1:0] & laneMask
                                    & ogt_pkg::slotMask(slot));
            end else if (hitCtrl && pstrb[0] && pwdata[ogt_pkg::CTRL_RELOAD]) begin
                s_nxt.start    = !ld.busy;
                s_nxt.fuseDone = 1'b0;
            end
        end

        // fuse words win over a software write to the same slot
        if (ld.wrEn) begin
            s_nxt.trim[ld.slot] = ld.data & ogt_pkg::slotMask(ld.slot);
            if (ld.slot == ogt_pkg::SLOT_LAST) begin
                s_nxt.fuseDone = 1'b1;
            end
        end

        // trim outputs, unsigned offsets, per-input sets follow the selects
        s_nxt.core0_fine_gain = s_r.trim[ogt_pkg::SLOT_CORE0_FINE_GAIN][ogt_pkg::GAIN_W-1:0];
        s_nxt.core1_fine_gain = s_r.trim[ogt_pkg::SLOT_CORE1_FINE_GAIN][ogt_pkg::GAIN_W-1:0];
        s_nxt.gain2 = core2SelB
                    ? s_r.trim[ogt_pkg::SLOT_CORE2_FINE_GAIN_INPUT_B][ogt_pkg::GAIN_W-1:0]
                    : s_r.trim[ogt_pkg::SLOT_CORE2_FINE_GAIN_INPUT_A][ogt_pkg::GAIN_W-1:0];
        s_nxt.gain3 = core3SelD
                    ? s_r.trim[ogt_pkg::SLOT_CORE3_FINE_GAIN_INPUT_D][ogt_pkg::GAIN_W-1:0]
                    : s_r.trim[ogt_pkg::SLOT_CORE3_FINE_GAIN_INPUT_C][ogt_pkg::GAIN_W-1:0];
        s_nxt.ofs3  = core3SelD
                    ? s_r.trim[ogt_pkg::SLOT_CORE3_OFFSET_INPUT_D][ogt_pkg::OFS_W-1:0]
                    : s_r.trim[ogt_pkg::SLOT_CORE3_OFFSET_INPUT_C][ogt_pkg::OFS_W-1:0];
        s_nxt.core4_offset  = s_r.trim[ogt_pkg::SLOT_CORE4_OFFSET][ogt_pkg::OFS_W-1:0];
        s_nxt.core5_offset  = s_r.trim[ogt_pkg::SLOT_CORE5_OFFSET][ogt_pkg::OFS_W-1:0];
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r.trim     <= '0;
            s_r.prdata   <= '0;
            s_r.pready   <= 1'b0;
            s_r.pslverr  <= 1'b0;
            s_r.start    <= 1'b0;
            s_r.fuseDone <= 1'b0;
            s_r.core0_fine_gain    <= '0;
            s_r.core1_fine_gain    <= '0;
            s_r.gain2    <= '0;
            s_r.gain3    <= '0;
            s_r.ofs3     <= '0;
            s_r.core4_offset     <= '0;
            s_r.core5_offset     <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign prdata      = s_r.prdata;
    assign pready      = s_r.pready;
    assign pslverr     = s_r.pslverr;
    assign core0Gain   = s_r.core0_fine_gain;
    assign core1Gain   = s_r.core1_fine_gain;
    assign core2Gain   = s_r.gain2;
    assign core3Gain   = s_r.gain3;
    assign core3Offset = s_r.ofs3;
    assign core4Offset = s_r.core4_offset;
    assign core5Offset = s_r.core5_offset;
    assign fuseLoading = ld.busy;

endmodule : ogt_trim_regs

// >>> ogt_trim_regs_asserts.sv
module ogt_trim_regs_asserts (
    input wire logic                        clk,
    input wire logic                        sys_rst,
    input wire logic [ogt_pkg::PADDR_W-1:0] paddr,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [ogt_pkg::PDATA_W-1:0] pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        core2SelB,
    input wire logic                        core3SelD,
    input wire logic [ogt_pkg::GAIN_W-1:0]  core0Gain,
    input wire logic [ogt_pkg::GAIN_W-1:0]  core2Gain,
    input wire logic [ogt_pkg::GAIN_W-1:0]  core3Gain,
    input wire logic [ogt_pkg::OFS_W-1:0]   core3Offset,
    input wire logic [ogt_pkg::OFS_W-1:0]   core4Offset,
    input wire logic [ogt_pkg::OFS_W-1:0]   core5Offset,
    input wire logic                        fuseLoading
);
    // ==========================================================
    // helper terms
    localparam logic [11:0] ADDR_CORE0_FINE_GAIN = ogt_pkg::IDX_CORE0_FINE_GAIN << 2;
    localparam logic [11:0] ADDR_CORE4_OFFSET  = ogt_pkg::IDX_CORE4_OFFSET << 2;
    localparam logic [11:0] ADDR_CORE5_OFFSET  = ogt_pkg::IDX_CORE5_OFFSET << 2;
    logic        quiet;
    logic        wrOk;
    logic [4:0]  wdGain;
    logic [11:0] wdOfs;
    // an accepted write may move a trim: all writes, refused ones too, are excluded from the hold checks
    assign quiet  = !fuseLoading && !(psel && pwrite);
    assign wrOk   = psel && penable && pwrite && pready && !pslverr && pstrb == 4'hf
                    && !fuseLoading;
    assign wdGain = pwdata[4:0];
    assign wdOfs  = pwdata[11:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // properties
    off4_hold_a: assert property (quiet [*3] |-> $stable(core4Offset))
        else $error("core4 offset moved without a write");
    gain2_sel_a: assert property ((quiet && $stable(core2SelB)) [*3] |-> $stable(core2Gain))
        else $error("core2 gain moved without cause");
    gain3_sel_a: assert property ((quiet && $stable(core3SelD)) [*3] |-> $stable(core3Gain))
        else $error("core3 gain moved without cause");
    off3_sel_a: assert property ((quiet && $stable(core3SelD)) [*3] |-> $stable(core3Offset))
        else $error("core3 offset moved without cause");
    core0_fine_gain_write_a: assert property (wrOk && paddr == ADDR_CORE0_FINE_GAIN |-> ##2 core0Gain == $past(wdGain, 2))
        else $error("core0 gain does not follow write");
    off4_write_a: assert property (wrOk && paddr == ADDR_CORE4_OFFSET |-> ##2 core4Offset == $past(wdOfs, 2))
        else $error("core4 offset does not follow write");
    off5_write_a: assert property (wrOk && paddr == ADDR_CORE5_OFFSET |-> ##2 core5Offset == $past(wdOfs, 2))
        else $error("core5 offset does not follow write");
    fuse_load_a: assert property ($fell(sys_rst) |-> fuseLoading ##[1:20] !fuseLoading)
        else $error("fuse load missing or too long");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_setup_a: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
        else $error("pready outside first access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    cover property (pslverr);
    cover property ($fell(fuseLoading));
    cover property ($changed(core3SelD) ##1 $changed(core3Offset));
endmodule : ogt_trim_regs_asserts

bind ogt_trim_regs ogt_trim_regs_asserts u_ogt_trim_regs_asserts (
    .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .core2SelB(core2SelB), .core3SelD(core3SelD), .core0Gain(core0Gain),
    .core2Gain(core2Gain), .core3Gain(core3Gain), .core3Offset(core3Offset),
    .core4Offset(core4Offset), .core5Offset(core5Offset), .fuseLoading(fuseLoading));

// >>> tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    localparam int LIMIT = 20000;
    localparam logic [11:0] IDX [10] = '{ogt_pkg::IDX_CORE3_OFFSET_INPUT_C, ogt_pkg::IDX_CORE3_OFFSET_INPUT_D,
        ogt_pkg::IDX_CORE4_OFFSET, ogt_pkg::IDX_CORE5_OFFSET, ogt_pkg::IDX_CORE0_FINE_GAIN, ogt_pkg::IDX_CORE1_FINE_GAIN,
        ogt_pkg::IDX_CORE2_FINE_GAIN_INPUT_A, ogt_pkg::IDX_CORE2_FINE_GAIN_INPUT_B, ogt_pkg::IDX_CORE3_FINE_GAIN_INPUT_C, ogt_pkg::IDX_CORE3_FINE_GAIN_INPUT_D};
    logic        clk;
    logic        sys_rst;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        core2SelB;
    logic        core3SelD;
    logic        calBusy;
    logic [15:0] fuseData;
    logic [3:0]  fuseAddr;
    logic [4:0]  core0Gain;
    logic [4:0]  core1Gain;
    logic [4:0]  core2Gain;
    logic [4:0]  core3Gain;
    logic [11:0] core3Offset;
    logic [11:0] core4Offset;
    logic [11:0] core5Offset;
    logic        fuseLoading;
    logic [31:0] rd;
    logic        er;
    logic [15:0] shadow [10];
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    ogt_trim_regs u_ogt_trim_regs (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core2SelB(core2SelB), .core3SelD(core3SelD),
        .calBusy(calBusy), .fuseData(fuseData), .fuseAddr(fuseAddr), .core0Gain(core0Gain),
        .core1Gain(core1Gain), .core2Gain(core2Gain), .core3Gain(core3Gain),
        .core3Offset(core3Offset), .core4Offset(core4Offset), .core5Offset(core5Offset),
        .fuseLoading(fuseLoading));

    // ==========================================================
    // fuse store, answers in the same cycle; each slot distinct
    function automatic logic [15:0] fuseVal(input logic [3:0] k);
        fuseVal = {4'h0, 4'h9 ^ k, 3'h0, 5'h11 + {1'b0, k}};
    endfunction : fuseVal
    assign fuseData = fuseVal(fuseAddr);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            wrap_up();
        end
    end

    // ==========================================================
    // tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // no local limit: the cycle ceiling ends a hung wait and counts it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp,
                         input logic expErr);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
        chk({what, " error"}, er, expErr);
    endtask : rdChk

    task automatic outChk();
        chk("core0Gain", core0Gain, shadow[4][4:0]);
        chk("core1Gain", core1Gain, shadow[5][4:0]);
        chk("core2Gain", core2Gain, shadow[core2SelB ? 7 : 6][4:0]);
        chk("core3Gain", core3Gain, shadow[core3SelD ? 9 : 8][4:0]);
        chk("core3Offset", core3Offset, shadow[core3SelD ? 1 : 0][11:0]);
        chk("core4Offset", core4Offset, shadow[2][11:0]);
        chk("core5Offset", core5Offset, shadow[3][11:0]);
    endtask : outChk

    task automatic allChk();
        for (int k = 0; k < 10; k++) begin
            rdChk("trim readback", IDX[k] << 2, {16'h0, shadow[k]}, 1'b0);
        end
        outChk();
    endtask : allChk

    // waits out a fuse load; gains keep only their low byte
    task automatic waitLoad();
        repeat (2) @(posedge clk);
        while (fuseLoading !== 1'b0) begin
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        for (int k = 0; k < 10; k++) begin
            shadow[k] = fuseVal(4'(k)) & (k < 4 ? 16'hffff : 16'h00ff);
        end
    endtask : waitLoad

    // ==========================================================
    // main sequence
    initial begin
        sys_rst   = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        pstrb     = 4'hf;
        core2SelB = 1'b0;
        core3SelD = 1'b0;
        calBusy   = 1'b0;
        repeat (4) @(posedge clk);
        chk("fuseLoading in reset", fuseLoading, 1'b1);
        chk("core4Offset in reset", core4Offset, 12'h000);
        sys_rst <= 1'b0;
        waitLoad();
        allChk();
        $display("test fuse defaults done");
        // reserved bits written as zero
        for (int k = 0; k < 10; k++) begin
            shadow[k] = {4'h0, 12'hfff - 12'(k * 'h111)} & (k < 4 ? 16'h0fff : 16'h001f);
            apb(1'b1, IDX[k] << 2, {16'h0, shadow[k]});
        end
        allChk();
        for (int s = 0; s < 4; s++) begin
            core2SelB <= s[0];
            core3SelD <= s[1];
            repeat (3) @(posedge clk);
            outChk();
        end
        $display("test writes and input selection done");
        calBusy <= 1'b1;
        apb(1'b1, ogt_pkg::IDX_CORE4_OFFSET << 2, 32'h0000_0321);
        chk("busy write error", er, 1'b1);
        rdChk("busy offset read", ogt_pkg::IDX_CORE4_OFFSET << 2, 32'h0, 1'b1);
        rdChk("busy gain read", ogt_pkg::IDX_CORE0_FINE_GAIN << 2, {16'h0, shadow[4]}, 1'b0);
        calBusy <= 1'b0;
        rdChk("offset after busy", ogt_pkg::IDX_CORE4_OFFSET << 2, {16'h0, shadow[2]}, 1'b0);
        $display("test calibration lockout done");
        rdChk("unmapped read", 12'hffc, 32'h0, 1'b1);
        rdChk("unaligned read", 12'hd81, 32'h0, 1'b1);
        apb(1'b1, ogt_pkg::IDX_STATUS << 2, 32'h0000_001f);
        chk("status write error", er, 1'b0);
        rdChk("status", ogt_pkg::IDX_STATUS << 2, {27'h0, core3SelD, core2SelB, 3'h1}, 1'b0);
        $display("test address map done");
        // low byte lane only, upper byte of the word must survive
        pstrb <= 4'h1;
        apb(1'b1, ogt_pkg::IDX_CORE4_OFFSET << 2, 32'h0000_0a5c);
        pstrb <= 4'hf;
        shadow[2][7:0] = 8'h5c;
        rdChk("byte lane write", ogt_pkg::IDX_CORE4_OFFSET << 2, {16'h0, shadow[2]}, 1'b0);
        outChk();
        $display("test byte lanes done");
        apb(1'b1, ogt_pkg::IDX_CTRL << 2, 32'h0000_0001);
        waitLoad();
        allChk();
        $display("test fuse reload done");
        wrap_up();
    end
endmodule : tb
